// *** dv/frag_source.sv ***
// Upstream fragment source model.
// Assumes a level valid held until ready is seen at a rising edge.
`timescale 1ns/1ps
module frag_source (
  input wire logic clock,
  input wire logic frag_ready,
  output logic frag_valid,
  output texture_lod_pkg::frag_req_type frag
);
  initial begin
    frag_valid = 1'b0;
    frag = '0;
  end
  task automatic send(input texture_lod_pkg::frag_req_type f);
    frag_valid <= 1'b1;
    frag <= f;
    @(posedge clock);
    while (frag_ready !== 1'b1) @(posedge clock);
    frag_valid <= 1'b0;
    frag <= ~f;
  endtask
endmodule

// *** dv/texture_lod_monitor.sv ***
// Port assertions for the LOD sampler front end.
// Assumes a bind onto the top module; one clock, reset active low.
`timescale 1ns/1ps
`include "texture_lod_cfg.svh"
module texture_lod_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frag_valid,
  input wire logic frag_ready,
  input wire logic res_valid,
  input wire texture_lod_pkg::frag_res_type res,
  input wire logic corner_valid,
  input wire logic [2:0][31:0] corner_texels,
  input wire logic corner_out_valid,
  input wire logic [31:0] corner_texel
);
  logic seam_r;
  logic [11:0] min_r;
  logic [11:0] max_r;
  logic [11:0] mag_r;
  logic wr_go;
  assign wr_go = psel && penable && pwrite && pready;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seam_r <= 1'b0;
    end else if (wr_go && paddr == `ADDR_SEAM_ON) begin
      seam_r <= 1'b1;
    end else if (wr_go && paddr == `ADDR_SEAM_OFF) begin
      seam_r <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      min_r <= `LOD_MIN_RST;
      max_r <= `LOD_MAX_RST;
      mag_r <= `MAG_C_RST;
    end else if (wr_go) begin
      if (paddr == `ADDR_LOD_MIN) min_r <= pwdata[11:0];
      if (paddr == `ADDR_LOD_MAX) max_r <= pwdata[11:0];
      if (paddr == `ADDR_MAG_C) mag_r <= pwdata[11:0];
    end
  end
  chk_res_latency: assert property (
    frag_valid && frag_ready |-> (##2 res_valid) or (##16 res_valid))
    else $error("result late");
  chk_busy_window: assert property (
    frag_valid && frag_ready |=> !frag_ready until res_valid)
    else $error("fragment taken while busy");
  chk_unmapped_err: assert property (
    psel && penable && paddr > 8'h24 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access");
  chk_seam_status: assert property (
    psel && penable && !pwrite && paddr == `ADDR_STATUS |-> prdata[0] == seam_r)
    else $error("seamless status bit wrong");
  chk_lod_clamp: assert property (
    res_valid && $signed(min_r) <= $signed(max_r) |->
      $signed(res.lambda) >= $signed(min_r) && $signed(res.lambda) <= $signed(max_r))
    else $error("lambda outside limits");
  chk_mag_class: assert property (
    res_valid |-> res.magnified == ($signed(res.lambda) <= $signed(mag_r)))
    else $error("magnified flag wrong");
  chk_nbr_border: assert property (
    res_valid && (res.nbr_u || res.nbr_v || res.corner) |-> seam_r && res.wrap == 6'h15)
    else $error("neighbour fetch out of mode");
  chk_seam_off: assert property (
    res_valid && !seam_r |-> !res.nbr_u && !res.nbr_v && !res.corner)
    else $error("neighbour fetch with seamless off");
  chk_corner_lat: assert property (
    corner_valid |=> corner_out_valid)
    else $error("corner texel late");
  chk_corner_same: assert property (
    corner_valid && corner_texels[0] == corner_texels[1] && corner_texels[1] == corner_texels[2]
      |=> corner_texel == $past(corner_texels[0]))
    else $error("corner of equal texels differs");
endmodule

// *** dv/texture_lod_seamless_cube_test.sv ***
// Self-checking bench for the LOD sampler front end.
// Assumes design, monitor and fragment source compiled first.
`timescale 1ns/1ps
module texture_lod_seamless_cube_test;
  typedef struct {
    logic [71:0] pos;
    logic [11:0] lam;
    logic mag;
    logic [5:0] wr;
    logic [2:0] fl;
    logic [2:0] fm;
    logic [3:0] sel;
  } note_type;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic frag_valid;
  logic frag_ready;
  texture_lod_pkg::frag_req_type frag;
  logic res_valid;
  texture_lod_pkg::frag_res_type res;
  logic corner_valid = 1'b0;
  logic [2:0][31:0] corner_texels = '0;
  logic corner_out_valid;
  logic [31:0] corner_texel;
  logic [11:0] cv = 12'h000;
  note_type q[$];
  logic [31:0] cq[$];
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  always #25 clock = ~clock;
  texture_lod_seamless_cube DUT (.clock, .rst_n, .psel, .penable, .paddr, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .frag_valid, .frag_ready, .frag, .res_valid, .res,
    .corner_valid, .corner_texels, .corner_out_valid, .corner_texel);
  frag_source src (.clock, .frag_ready, .frag_valid, .frag);
  task automatic chk(input string what, input logic [71:0] e, input logic [71:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wrap_up;
    chk("pending", 72'h0, q.size());
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    if (a == 8'h20) cv = d[11:0];
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", x, r & m);
    chk("pslverr", ee, e);
  endtask
  task automatic go(input texture_lod_pkg::frag_req_type f, input note_type n);
    q.push_back(n);
    src.send(f);
    while (q.size() > 0) @(posedge clock);
  endtask
  task automatic lod(input logic [15:0] dx, input logic [15:0] dy, input logic ln,
                     input logic [11:0] ob, input logic [1:0] bs, input logic [11:0] sb,
                     input logic [11:0] x);
    texture_lod_pkg::frag_req_type f;
    note_type n;
    wr(8'h14, {20'h0_0000, ob});
    f = '0;
    f.deriv_x[0] = dx;
    f.deriv_y[0] = dy;
    f.is_line = ln;
    f.line_dx = 16'h0004;
    {f.has_bias, f.in_frag_shader} = bs;
    f.shader_bias = sb;
    n = '{default: '0};
    n.lam = x;
    n.mag = $signed(x) <= $signed(cv);
    n.sel = 4'h2;
    go(f, n);
  endtask
  task automatic lod_a(input logic [11:0] x);
    lod(16'h0100, 16'h0800, 1'b0, 12'h000, 2'b00, 12'h000, x);
  endtask
  task automatic cube(input logic [15:0] sc, input logic [15:0] tc, input logic [5:0] wx,
                      input logic [2:0] fl, input logic [2:0] fm);
    texture_lod_pkg::frag_req_type f;
    note_type n;
    f = '0;
    f.coord = {16'h1000, tc, sc};
    n = '{default: '0};
    n.pos[47:24] = (tc == 16'h0000) ? 24'h00_0800 : 24'h00_0000;
    n.pos[23:0] = (sc == 16'h0000) ? 24'h00_0800 : 24'h00_0000;
    n.wr = wx;
    n.fl = fl & fm;
    n.fm = fm;
    n.sel = 4'hd;
    go(f, n);
  endtask
  task automatic corner(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                        input logic [31:0] x);
    cq.push_back(x);
    corner_valid <= 1'b1;
    corner_texels <= {c, b, a};
    @(posedge clock);
    corner_valid <= 1'b0;
    corner_texels <= ~{c, b, a};
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    note_type nt;
    cyc <= cyc + 1;
    if (res_valid === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      if (nt.sel[0]) chk("texel_pos", nt.pos, res.texel_pos);
      if (nt.sel[1]) chk("lambda", nt.lam, res.lambda);
      if (nt.sel[1]) chk("magnified", nt.mag, res.magnified);
      if (nt.sel[2]) chk("wrap", nt.wr, res.wrap);
      if (nt.sel[3]) chk("flags", nt.fl, {res.nbr_u, res.nbr_v, res.corner} & nt.fm);
    end else if (res_valid === 1'b1) begin
      chk("res_extra", 72'h0, 72'h1);
    end
    if (corner_out_valid === 1'b1 && cq.size() > 0) chk("corner", cq.pop_front(), corner_texel);
    if (cyc == 20000) begin
      chk("timeout", 72'h0, 72'h1);
      wrap_up();
    end
  end
  initial begin
    texture_lod_pkg::frag_req_type f;
    note_type n;
    int o[3];
    logic [5:0] w6;
    logic [31:0] t32;
    void'($urandom(32'hfc71));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(8'h08, 32'h0000_0000, 32'h0000_0001, 1'b0);
    rd(8'h18, 32'h0000_0800, 32'h0000_0fff, 1'b0);
    rd(8'h1c, 32'h0000_07ff, 32'h0000_0fff, 1'b0);
    rd(8'h30, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    wr(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0001, 32'h0000_0001, 1'b0);
    wr(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000, 32'h0000_0001, 1'b0);
    wr(8'h0c, 32'h0008_0010);
    for (int t = 0; t < 7; t++) begin
      if (t != 5) begin
        w6 = 6'($urandom);
        wr(8'h10, 32'(4 + (t << 16) + (w6 << 24)));
        f = '0;
        f.coord = {16'h0800, 16'h0800, 16'h0800};
        f.has_offset = 1'($urandom);
        f.offset = 12'($urandom);
        for (int i = 0; i < 3; i++) o[i] = f.has_offset ? $signed(f.offset[i]) * 256 : 0;
        n = '{default: '0};
        n.pos[23:0] = 24'(((t == 4) ? 128 : 2048) + o[0]);
        n.pos[47:24] = (t < 2) ? 24'h00_0000 : 24'(((t == 4) ? 128 : 1024) + o[1]);
        n.pos[71:48] = (t == 6) ? 24'(512 + o[2]) : 24'h00_0000;
        n.wr = w6;
        n.sel = 4'h5;
        go(f, n);
      end
    end
    wr(8'h10, 32'h0002_0004);
    lod_a(12'h030);
    lod(16'h0100, 16'h0800, 1'b1, 12'h000, 2'b00, 12'h000, 12'h000);
    lod(16'h0200, 16'h0000, 1'b0, 12'h0f0, 2'b11, 12'h050, 12'h110);
    lod(16'h0200, 16'h0000, 1'b0, 12'h0f0, 2'b01, 12'h050, 12'h100);
    lod(16'h0200, 16'h0000, 1'b0, 12'h0f0, 2'b10, 12'h050, 12'h100);
    lod(16'h0200, 16'h0000, 1'b0, 12'hf10, 2'b11, 12'hfb0, 12'hf10);
    wr(8'h20, 32'h0000_0030);
    lod_a(12'h030);
    wr(8'h20, 32'h0000_002f);
    lod_a(12'h030);
    wr(8'h1c, 32'h0000_0020);
    lod_a(12'h020);
    wr(8'h1c, 32'h0000_07ff);
    wr(8'h18, 32'h0000_0040);
    lod_a(12'h040);
    wr(8'h18, 32'h0000_0800);
    wr(8'h0c, 32'h0010_0010);
    wr(8'h10, 32'h2a05_0004);
    cube(16'h0000, 16'h0000, 6'h2a, 3'b000, 3'b111);
    wr(8'h10, 32'h2a15_0004);
    cube(16'hf000, 16'h0000, 6'h2a, 3'b000, 3'b111);
    wr(8'h00, 32'h0000_0000);
    wr(8'h10, 32'h2a05_0004);
    cube(16'h0000, 16'h0000, 6'h00, 3'b000, 3'b111);
    wr(8'h10, 32'h2a15_0004);
    cube(16'h0000, 16'h0000, 6'h15, 3'b000, 3'b111);
    cube(16'hf000, 16'h0000, 6'h15, 3'b100, 3'b111);
    cube(16'h0000, 16'hf000, 6'h15, 3'b010, 3'b111);
    cube(16'hf000, 16'hf000, 6'h15, 3'b001, 3'b001);
    rd(8'h24, 32'h0000_0017, 32'hffff_ffff, 1'b0);
    t32 = $urandom;
    corner(t32, t32, t32, t32);
    corner(32'h3030_3030, 32'h6060_6060, 32'h9090_9090, 32'h6060_6060);
    repeat (20) @(posedge clock);
    wrap_up();
  end
endmodule
bind texture_lod_seamless_cube texture_lod_monitor mon (
  .clock, .rst_n, .psel, .penable, .paddr, .pwrite, .pwdata, .prdata, .pready, .pslverr,
  .frag_valid, .frag_ready, .res_valid, .res, .corner_valid, .corner_texels,
  .corner_out_valid, .corner_texel
);

// *** inc/texture_lod_cfg.svh ***
// Register offsets, field positions, reset values and step counts for the LOD sampler.
// Assumes APB byte addresses on an 8-bit paddr, one 32-bit word per register.
`ifndef TEXTURE_LOD_CFG_SVH
`define TEXTURE_LOD_CFG_SVH
`define ADDR_SEAM_ON 8'h00
`define ADDR_SEAM_OFF 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_SIZE_WH 8'h0C
`define ADDR_SIZE_D 8'h10
`define ADDR_LOD_BIAS 8'h14
`define ADDR_LOD_MIN 8'h18
`define ADDR_LOD_MAX 8'h1C
`define ADDR_MAG_C 8'h20
`define ADDR_FRAG_CNT 8'h24
`define WH_HEIGHT_LSB 16
`define D_TARGET_LSB 16
`define D_LINEAR_BIT 20
`define D_WRAP_LSB 24
`define SIZE_RST 12'h001
`define LOD_MIN_RST 12'h800
`define LOD_MAX_RST 12'h7FF
`define LOD_BIAS_RST 12'h000
`define MAG_C_RST 12'h000
`define BIAS_MAX 14'h0100
`define POS_HALF 24'h00_0080
`define POS_FRAC_LOG 14'h0080
`define FACE_ONE 14'h1000
`define DIV_STEPS 4'hD
`endif

// *** inc/texture_lod_pkg.sv ***
// Types shared by the LOD sampler and its helpers.
// Coordinates are signed Q4.12, texel positions signed Q16.8, LOD signed Q8.4.
package texture_lod_pkg;
  typedef enum logic [1:0] {
    edge_clamp_wrap = 2'h0,
    border_clamp_wrap = 2'h1,
    repeat_wrap = 2'h2,
    mirror_repeat_wrap = 2'h3
  } wrap_type;
  typedef enum logic [2:0] {
    tex_1d = 3'h0,
    tex_1d_array = 3'h1,
    tex_2d = 3'h2,
    tex_2d_array = 3'h3,
    tex_rect = 3'h4,
    tex_cube = 3'h5,
    tex_3d = 3'h6
  } target_type;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_divide = 2'h1,
    st_finish = 2'h2
  } seq_state_type;
  // Cube lookups carry s_c, t_c, m_a in coord[0..2]
  typedef struct packed {
    logic [2:0][15:0] coord;
    logic [2:0][15:0] deriv_x;
    logic [2:0][15:0] deriv_y;
    logic [15:0] line_dx;
    logic [15:0] line_dy;
    logic is_line;
    logic has_offset;
    logic [2:0][3:0] offset;
    logic has_bias;
    logic in_frag_shader;
    logic [11:0] shader_bias;
  } frag_req_type;
  typedef struct packed {
    logic [2:0][23:0] texel_pos;
    logic [11:0] lambda;
    logic magnified;
    wrap_type [2:0] wrap;
    logic nbr_u;
    logic nbr_v;
    logic corner;
  } frag_res_type;
endpackage

// *** rtl/corner_avg.sv ***
// Averages three RGBA8 texels per channel to build the missing cube corner texel.
// Divide by three is a multiply by 171 and shift; equal inputs return that value.
`timescale 1ns/1ps
module corner_avg (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [2:0][31:0] texels,
  output logic out_valid,
  output logic [31:0] texel
);
  logic [31:0] avg;
  genvar ch;
  for (ch = 0; ch < 4; ch++) begin : g_chan
    logic [9:0] sum;
    logic [17:0] prod;
    assign sum = {2'b00, texels[0][ch*8+:8]} + {2'b00, texels[1][ch*8+:8]}
               + {2'b00, texels[2][ch*8+:8]};
    assign prod = sum * 8'hAB;
    assign avg[ch*8+:8] = prod[16:9];
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      texel <= 32'h0000_0000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        texel <= avg;
      end
    end
  end
endmodule

// *** rtl/frac_divider.sv ***
// Restoring divider giving numer/denom as unsigned Q1.12, for numer <= denom.
// Start is a one-cycle pulse; done pulses once 13 steps later.
`timescale 1ns/1ps
`include "texture_lod_cfg.svh"
module frac_divider (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [15:0] numer,
  input wire logic [15:0] denom,
  output logic done,
  output logic [12:0] quot
);
  logic [16:0] rem_r;
  logic [15:0] den_r;
  logic [3:0] cnt_r;
  logic busy_r;
  logic [12:0] quot_r;
  logic ge;
  logic [16:0] diff;
  assign ge = rem_r >= {1'b0, den_r};
  assign diff = rem_r - {1'b0, den_r};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= 17'h0_0000;
      den_r <= 16'h0000;
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      quot_r <= 13'h0000;
    end else if (start) begin
      rem_r <= {1'b0, numer};
      den_r <= denom;
      cnt_r <= `DIV_STEPS;
      busy_r <= 1'b1;
      quot_r <= 13'h0000;
    end else if (cnt_r != 4'h0) begin
      quot_r <= {quot_r[11:0], ge};
      rem_r <= {(ge ? diff[15:0] : rem_r[15:0]), 1'b0};
      cnt_r <= cnt_r - 4'h1;
    end else begin
      busy_r <= 1'b0;
    end
  end
  assign done = busy_r && (cnt_r == 4'h0);
  assign quot = quot_r;
endmodule

// *** rtl/texture_lod_seamless_cube.sv ***
// Texture sampler front end: texel coordinates, scale factor, LOD and seamless cube control.
// Assumes one fragment in flight, APB register access, and config held stable per fragment.
`timescale 1ns/1ps
`include "texture_lod_cfg.svh"
module texture_lod_seamless_cube (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frag_valid,
  output logic frag_ready,
  input wire texture_lod_pkg::frag_req_type frag,
  output logic res_valid,
  output texture_lod_pkg::frag_res_type res,
  input wire logic corner_valid,
  input wire logic [2:0][31:0] corner_texels,
  output logic corner_out_valid,
  output logic [31:0] corner_texel
);
  logic seamless_r;
  logic [11:0] width_r;
  logic [11:0] height_r;
  logic [11:0] depth_r;
  texture_lod_pkg::target_type target_r;
  logic linear_r;
  typedef texture_lod_pkg::wrap_type [2:0] wrap3_type;
  texture_lod_pkg::wrap_type [2:0] wrap_r;
  logic [11:0] bias_r;
  logic [11:0] lod_min_r;
  logic [11:0] lod_max_r;
  logic [11:0] mag_c_r;
  logic [31:0] frag_cnt_r;
  texture_lod_pkg::seq_state_type state_r;
  texture_lod_pkg::seq_state_type state_nxt;
  texture_lod_pkg::frag_req_type req_r;
  logic setup;
  logic access;
  logic wr;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic accept;
  logic is_cube;
  logic div_done_s;
  logic div_done_t;
  logic [12:0] quot_s;
  logic [12:0] quot_t;
  logic [15:0] face_s;
  logic [15:0] face_t;
  logic [2:0][15:0] norm;
  logic [2:0][11:0] size_v;
  logic [2:0] axis_live;
  logic [2:0] border;
  logic [2:0][23:0] pos;
  logic [2:0][23:0] mag_axis;
  logic [2:0][39:0] proj_axis;
  logic [39:0] rho_num;
  logic [15:0] len_max;
  logic [13:0] lod_base;
  logic [13:0] bias_sum;
  logic [13:0] bias_clamped;
  logic [13:0] lod_biased;
  logic [11:0] lambda;
  logic seam_cube;
  texture_lod_pkg::wrap_type [2:0] wrap_eff;

  function automatic logic [15:0] mag16(input logic [15:0] v);
    mag16 = v[15] ? 16'(-v) : v;
  endfunction

  // Normalized Q4.12 to texel Q16.8, scaled by size unless rectangular
  function automatic logic [23:0] scale(input logic [15:0] c, input logic [11:0] sz,
                                        input logic rect);
    logic [28:0] prod;
    prod = 29'($signed({1'b0, sz}) * $signed(c));
    scale = rect ? {{12{c[15]}}, c[15:4]} : prod[27:4];
  endfunction

  // Log2 of an unsigned value as signed Q8.4; zero gives the most negative LOD
  function automatic logic [11:0] log2_fx(input logic [39:0] v);
    logic [5:0] p;
    logic [39:0] n;
    p = 6'h00;
    n = 40'h00_0000_0000;
    for (int i = 0; i < 40; i++) begin
      if (v[i]) begin
        p = 6'(i);
      end
    end
    n = v << (6'd39 - p);
    log2_fx = (v == 40'h00_0000_0000) ? `LOD_MIN_RST : {2'b00, p, n[38:35]};
  endfunction

  // APB slave: zero wait states, read data latched in the setup cycle
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = 1'b1;
  assign pslverr = access && !addr_hit;

  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `ADDR_SEAM_ON, `ADDR_SEAM_OFF: rd_mux = 32'h0000_0000;
      `ADDR_STATUS: rd_mux = {30'h0000_0000, state_r != texture_lod_pkg::st_idle, seamless_r};
      `ADDR_SIZE_WH: rd_mux = {4'h0, height_r, 4'h0, width_r};
      `ADDR_SIZE_D: rd_mux = {2'b00, wrap_r, 3'b000, linear_r, 1'b0, target_r, 4'h0, depth_r};
      `ADDR_LOD_BIAS: rd_mux = {20'h0_0000, bias_r};
      `ADDR_LOD_MIN: rd_mux = {20'h0_0000, lod_min_r};
      `ADDR_LOD_MAX: rd_mux = {20'h0_0000, lod_max_r};
      `ADDR_MAG_C: rd_mux = {20'h0_0000, mag_c_r};
      `ADDR_FRAG_CNT: rd_mux = frag_cnt_r;
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seamless_r <= 1'b0;
    end else if (wr && paddr == `ADDR_SEAM_ON) begin
      seamless_r <= 1'b1;
    end else if (wr && paddr == `ADDR_SEAM_OFF) begin
      seamless_r <= 1'b0;
    end
  end

  // Texture object parameters
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      width_r <= `SIZE_RST;
      height_r <= `SIZE_RST;
      depth_r <= `SIZE_RST;
      target_r <= texture_lod_pkg::tex_2d;
      linear_r <= 1'b0;
      wrap_r <= wrap3_type'({3{texture_lod_pkg::repeat_wrap}});
      bias_r <= `LOD_BIAS_RST;
      lod_min_r <= `LOD_MIN_RST;
      lod_max_r <= `LOD_MAX_RST;
      mag_c_r <= `MAG_C_RST;
    end else if (wr) begin
      case (paddr)
        `ADDR_SIZE_WH: begin
          width_r <= pwdata[11:0];
          height_r <= pwdata[`WH_HEIGHT_LSB+:12];
        end
        `ADDR_SIZE_D: begin
          depth_r <= pwdata[11:0];
          target_r <= texture_lod_pkg::target_type'(pwdata[`D_TARGET_LSB+:3]);
          linear_r <= pwdata[`D_LINEAR_BIT];
          wrap_r <= wrap3_type'(pwdata[`D_WRAP_LSB+:6]);
        end
        `ADDR_LOD_BIAS: bias_r <= pwdata[11:0];
        `ADDR_LOD_MIN: lod_min_r <= pwdata[11:0];
        `ADDR_LOD_MAX: lod_max_r <= pwdata[11:0];
        `ADDR_MAG_C: mag_c_r <= pwdata[11:0];
        default: begin
        end
      endcase
    end
  end

  // Fragment sequencing: cube lookups wait for the face divide
  assign frag_ready = state_r == texture_lod_pkg::st_idle;
  assign accept = frag_valid && frag_ready;
  assign is_cube = target_r == texture_lod_pkg::tex_cube;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      texture_lod_pkg::st_idle: begin
        if (accept) begin
          state_nxt = is_cube ? texture_lod_pkg::st_divide : texture_lod_pkg::st_finish;
        end
      end
      texture_lod_pkg::st_divide: begin
        if (div_done_s) begin
          state_nxt = texture_lod_pkg::st_finish;
        end
      end
      texture_lod_pkg::st_finish: state_nxt = texture_lod_pkg::st_idle;
      default: state_nxt = texture_lod_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= texture_lod_pkg::st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= '0;
    end else if (accept) begin
      req_r <= frag;
    end
  end

  frac_divider u_div_s (
    .clock(clock),
    .rst_n(rst_n),
    .start(accept && is_cube),
    .numer(mag16(frag.coord[0])),
    .denom(mag16(frag.coord[2])),
    .done(div_done_s),
    .quot(quot_s)
  );

  frac_divider u_div_t (
    .clock(clock),
    .rst_n(rst_n),
    .start(accept && is_cube),
    .numer(mag16(frag.coord[1])),
    .denom(mag16(frag.coord[2])),
    .done(div_done_t),
    .quot(quot_t)
  );

  // Face coordinate is (1 +/- quotient) / 2
  always_comb begin
    logic [13:0] sum_s;
    logic [13:0] sum_t;
    sum_s = req_r.coord[0][15] ? `FACE_ONE - {1'b0, quot_s} : `FACE_ONE + {1'b0, quot_s};
    sum_t = req_r.coord[1][15] ? `FACE_ONE - {1'b0, quot_t} : `FACE_ONE + {1'b0, quot_t};
    face_s = {3'b000, sum_s[13:1]};
    face_t = {3'b000, sum_t[13:1]};
    norm[0] = is_cube ? face_s : req_r.coord[0];
    norm[1] = is_cube ? face_t : req_r.coord[1];
    norm[2] = req_r.coord[2];
  end

  assign size_v = {depth_r, height_r, width_r};
  assign axis_live[0] = 1'b1;
  assign axis_live[1] = target_r != texture_lod_pkg::tex_1d
                     && target_r != texture_lod_pkg::tex_1d_array;
  assign axis_live[2] = target_r == texture_lod_pkg::tex_3d;
  assign seam_cube = seamless_r && is_cube;

  genvar g;
  for (g = 0; g < 3; g++) begin : g_axis
    logic rect;
    logic [23:0] off_pos;
    logic [23:0] du_x;
    logic [23:0] du_y;
    logic [23:0] abs_x;
    logic [23:0] abs_y;
    logic [40:0] proj;
    logic [23:0] base_i;
    logic [16:0] last_i;
    assign rect = (target_r == texture_lod_pkg::tex_rect) && (g < 2);
    assign off_pos = req_r.has_offset
                   ? {{12{req_r.offset[g][3]}}, req_r.offset[g], 8'h00}
                   : 24'h00_0000;
    assign pos[g] = axis_live[g] ? scale(norm[g], size_v[g], rect) + off_pos
                                 : 24'h00_0000;
    assign du_x = axis_live[g] ? scale(req_r.deriv_x[g], size_v[g], rect) : 24'h00_0000;
    assign du_y = axis_live[g] ? scale(req_r.deriv_y[g], size_v[g], rect) : 24'h00_0000;
    assign abs_x = du_x[23] ? 24'(-du_x) : du_x;
    assign abs_y = du_y[23] ? 24'(-du_y) : du_y;
    assign mag_axis[g] = (abs_x > abs_y) ? abs_x : abs_y;
    assign proj = 41'($signed(du_x) * $signed(req_r.line_dx))
                + 41'($signed(du_y) * $signed(req_r.line_dy));
    assign proj_axis[g] = proj[40] ? 40'(-proj) : proj[39:0];
    // Linear footprint leaves the face when i0 < 0 or i1 >= size
    assign base_i = pos[g] - `POS_HALF;
    assign last_i = {5'h00, size_v[g]} - 17'h0_0001;
    assign border[g] = base_i[23] || ($signed({base_i[23], base_i[23:8]}) >= $signed(last_i));
    assign wrap_eff[g] = seam_cube ? (linear_r ? texture_lod_pkg::border_clamp_wrap
                                               : texture_lod_pkg::edge_clamp_wrap)
                                   : wrap_r[g];
  end

  // Scale factor as largest per-axis term, kept in log domain
  always_comb begin
    logic [15:0] ax;
    logic [15:0] ay;
    rho_num = 40'h00_0000_0000;
    ax = mag16(req_r.line_dx);
    ay = mag16(req_r.line_dy);
    len_max = (ax > ay) ? ax : ((ay == 16'h0000) ? 16'h0001 : ay);
    for (int a = 0; a < 3; a++) begin
      if (req_r.is_line) begin
        if (proj_axis[a] > rho_num) begin
          rho_num = proj_axis[a];
        end
      end else if ({16'h0000, mag_axis[a]} > rho_num) begin
        rho_num = {16'h0000, mag_axis[a]};
      end
    end
  end

  always_comb begin
    logic [11:0] shader;
    logic [13:0] lg_len;
    logic [11:0] lg_rho;
    lg_rho = log2_fx(rho_num);
    lg_len = req_r.is_line ? {{2{1'b0}}, log2_fx({24'h00_0000, len_max})} : 14'h0000;
    lod_base = {{2{lg_rho[11]}}, lg_rho}
             - `POS_FRAC_LOG - lg_len;
    shader = (req_r.has_bias && req_r.in_frag_shader) ? req_r.shader_bias
                                                      : 12'h000;
    bias_sum = {{2{bias_r[11]}}, bias_r} + {{2{shader[11]}}, shader};
    if ($signed(bias_sum) > $signed(`BIAS_MAX)) begin
      bias_clamped = `BIAS_MAX;
    end else if ($signed(bias_sum) < -$signed(`BIAS_MAX)) begin
      bias_clamped = 14'(-`BIAS_MAX);
    end else begin
      bias_clamped = bias_sum;
    end
    lod_biased = lod_base + bias_clamped;
    if ($signed(lod_biased) > $signed({{2{lod_max_r[11]}}, lod_max_r})) begin
      lambda = lod_max_r;
    end else if ($signed(lod_biased) < $signed({{2{lod_min_r[11]}}, lod_min_r})) begin
      lambda = lod_min_r;
    end else begin
      lambda = lod_biased[11:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      res <= '0;
      res_valid <= 1'b0;
    end else begin
      res_valid <= state_r == texture_lod_pkg::st_finish;
      if (state_r == texture_lod_pkg::st_finish) begin
        res.texel_pos <= pos;
        res.lambda <= lambda;
        res.magnified <= $signed(lambda) <= $signed(mag_c_r);
        res.wrap <= wrap_eff;
        res.nbr_u <= seam_cube && linear_r && border[0] && !border[1];
        res.nbr_v <= seam_cube && linear_r && border[1] && !border[0];
        res.corner <= seam_cube && linear_r && border[0] && border[1];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frag_cnt_r <= 32'h0000_0000;
    end else if (state_r == texture_lod_pkg::st_finish) begin
      frag_cnt_r <= frag_cnt_r + 32'h0000_0001;
    end
  end

  corner_avg u_corner (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(corner_valid),
    .texels(corner_texels),
    .out_valid(corner_out_valid),
    .texel(corner_texel)
  );
endmodule
